// ### hw/madc_control.sv
`timescale 1ns/100ps
module madc_control
   import madc_pkg::*;
#(
   parameter logic [2:0] SILICON_REVISION = 3'h0 // arbitrary value
)
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [7:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata,
   input  wire logic                   conv_done,
   input  wire madc_pkg::madc_sample_t conv_sample,
   output logic                        conv_start,
   output madc_pkg::madc_conv_ch_t     conv_channel,
   output logic                        buffer_bypass,
   output logic                        input_swap
);
   import madc_pkg::*;

   logic          enable;
   logic          one_shot;
   logic          all_channel_sweep;
   madc_conv_ch_t conversion_channel_select;
   madc_rb_ch_t   readback_channel_select;
   logic          data_ready;
   madc_result_t  results [NUM_CHANNELS];
   madc_result_t  view;
   logic          capture;
   logic [2:0]    capture_ch;
   logic          setup_wr;
   logic          chan_wr;
   logic          restart;
   logic          lower_rd;

   // a raw sample placed into the two readable bytes
   function automatic madc_result_t format_sample(input madc_sample_t s);
      madc_result_t r;
      if (s.is_8bit)
      begin
         r.upper = s.data[7:0];
         r.lower = 8'h00;
      end
      else
      begin
         r.upper = s.data[13:6];
         r.lower = {2'b00, s.data[5:0]};
      end
      return r;
   endfunction

   assign setup_wr = reg_wr && (reg_addr == OFF_SETUP);
   assign chan_wr  = reg_wr && (reg_addr == OFF_CHANNEL);
   assign lower_rd = reg_rd && (reg_addr == OFF_RESULT_LOWER);
   // any setup or select change starts a fresh pass
   assign restart  = setup_wr || chan_wr;
   assign view     = results[readback_channel_select];

   // writable setup fields; revision bits are not stored
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         {enable, one_shot, all_channel_sweep, buffer_bypass, input_swap} <= SETUP_RESET;
      end
      else if (setup_wr)
      begin
         enable            <= reg_wdata[BIT_ENABLE];
         one_shot          <= reg_wdata[BIT_ONE_SHOT];
         all_channel_sweep <= reg_wdata[BIT_SWEEP];
         buffer_bypass     <= reg_wdata[BIT_BYPASS];
         input_swap        <= reg_wdata[BIT_SWAP];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         readback_channel_select   <= madc_rb_ch_t'(SEL_RESET);
         conversion_channel_select <= madc_conv_ch_t'(SEL_RESET);
      end
      else if (chan_wr)
      begin
         readback_channel_select   <= madc_rb_ch_t'(reg_wdata[RB_SEL_LSB +: 3]);
         conversion_channel_select <= madc_conv_ch_t'(reg_wdata[CONV_SEL_LSB +: 3]);
      end
   end

   // ready clears on a read of the lower byte; a new result in that cycle wins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_ready <= 1'b0;
      end
      else if (capture)
      begin
         data_ready <= 1'b1;
      end
      else if (lower_rd)
      begin
         data_ready <= 1'b0;
      end
   end

   // per-channel store, only the sequencer writes it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CHANNELS; i++)
         begin
            results[i] <= '0;
         end
      end
      else if (capture)
      begin
         results[capture_ch] <= format_sample(conv_sample);
      end
   end

   // read data stands until the next read
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= RDATA_RESET;
      end
      else if (reg_rd)
      begin
         unique case (reg_addr)
            OFF_RESULT_UPPER: reg_rdata <= view.upper;
            OFF_RESULT_LOWER: reg_rdata <= view.lower;
            OFF_SETUP:        reg_rdata <= {enable, one_shot, all_channel_sweep,
                                            buffer_bypass, input_swap,
                                            SILICON_REVISION};
            OFF_CHANNEL:      reg_rdata <= {data_ready, 1'b0, readback_channel_select,
                                            conversion_channel_select};
            default:          reg_rdata <= RDATA_RESET;
         endcase
      end
   end

   madc_sequencer i_madc_sequencer
   (
      .clk          (clk),
      .rst          (rst),
      .enable       (enable),
      .one_shot     (one_shot),
      .sweep        (all_channel_sweep),
      .sel_ch       (conversion_channel_select),
      .restart      (restart),
      .conv_done    (conv_done),
      .conv_start   (conv_start),
      .conv_channel (conv_channel),
      .capture      (capture),
      .capture_ch   (capture_ch)
   );

   property p_upper_14;
      @(posedge clk) disable iff (rst)
      capture && !conv_sample.is_8bit && capture_ch == 3'(readback_channel_select)
         ##1 !capture && !restart
         ##1 reg_rd && reg_addr == OFF_RESULT_UPPER && !capture && !restart
      |=> reg_rdata == $past(conv_sample.data[13:6], 3);
   endproperty
   a_upper_14: assert property (p_upper_14)
      else $error("upper byte is not bits 13..6 of the result");

   property p_lower_top_zero;
      @(posedge clk) disable iff (rst)
      lower_rd |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_lower_top_zero: assert property (p_lower_top_zero)
      else $error("reserved lower-byte bits not zero");

   property p_write_ignored;
      @(posedge clk) disable iff (rst)
      reg_wr && (reg_addr == OFF_RESULT_UPPER || reg_addr == OFF_RESULT_LOWER) && !capture
      |=> $stable(view);
   endproperty
   a_write_ignored: assert property (p_write_ignored)
      else $error("write changed a result byte");

   property p_ready_after_capture;
      @(posedge clk) disable iff (rst)
      capture |=> (data_ready and (!lower_rd |=> data_ready));
   endproperty
   a_ready_after_capture: assert property (p_ready_after_capture)
      else $error("ready flag not set after a conversion");

   property p_single_channel;
      @(posedge clk) disable iff (rst)
      conv_start && !all_channel_sweep && !$past(restart)
      |-> conv_channel == conversion_channel_select;
   endproperty
   a_single_channel: assert property (p_single_channel)
      else $error("single-channel mode converted another channel");

   property p_bypass_follows;
      @(posedge clk) disable iff (rst)
      setup_wr |=> buffer_bypass == $past(reg_wdata[BIT_BYPASS])
         && input_swap == $past(reg_wdata[BIT_SWAP]);
   endproperty
   a_bypass_follows: assert property (p_bypass_follows)
      else $error("buffer bits did not follow the setup write");

   property p_revision;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == OFF_SETUP |=> reg_rdata[REV_MSB:0] == SILICON_REVISION;
   endproperty
   a_revision: assert property (p_revision)
      else $error("revision field wrong");

   property p_hold_disabled;
      @(posedge clk) disable iff (rst)
      // a select write moves the view legitimately, so only quiet cycles count
      !enable && !chan_wr |=> $stable(view);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled)
      else $error("stored result changed while disabled");

   property p_readback_select;
      @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == OFF_CHANNEL |=> reg_rdata[5:3] == $past(3'(readback_channel_select));
   endproperty
   a_readback_select: assert property (p_readback_select)
      else $error("readback select field wrong");

endmodule

// ### hw/madc_pkg.sv
package madc_pkg;

   // register offsets
   localparam logic [7:0] OFF_RESULT_UPPER = 8'h07;
   localparam logic [7:0] OFF_RESULT_LOWER = 8'h08;
   localparam logic [7:0] OFF_SETUP        = 8'h09;
   localparam logic [7:0] OFF_CHANNEL      = 8'h0a;

   // converter_setup field positions
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_ONE_SHOT = 6;
   localparam int BIT_SWEEP    = 5;
   localparam int BIT_BYPASS   = 4;
   localparam int BIT_SWAP     = 3;
   localparam int REV_MSB      = 2;

   // channel register field positions
   localparam int BIT_READY    = 7;
   localparam int RB_SEL_LSB   = 3;
   localparam int CONV_SEL_LSB = 0;

   // values after reset, and the first and last sweep channel
   localparam logic [4:0] SETUP_RESET   = 5'h00;
   localparam logic [2:0] SEL_RESET     = 3'h0;
   localparam logic [7:0] RDATA_RESET   = 8'h00;
   localparam logic [2:0] LAST_CHANNEL  = 3'h7;
   localparam logic [2:0] FIRST_CHANNEL = 3'h0;

   localparam int RESULT_BITS  = 14;
   localparam int NUM_CHANNELS = 8;

   // conversion channel codes
   typedef enum logic [2:0]
   {
      CONV_CURRENT_LIMIT = 3'h0,
      CONV_INPUT         = 3'h1,
      CONV_BATTERY       = 3'h2,
      CONV_OUTPUT_LIMIT  = 3'h3,
      CONV_THERMISTOR    = 3'h4,
      CONV_DIE_TEMP      = 3'h5,
      CONV_EXTERNAL      = 3'h6,
      CONV_GROUND        = 3'h7
   } madc_conv_ch_t;

   // readback channel codes
   typedef enum logic [2:0]
   {
      RB_OUTPUT_LIMIT  = 3'h0,
      RB_OUTPUT_VOLT   = 3'h1,
      RB_INPUT_VOLT    = 3'h2,
      RB_CURRENT_LIMIT = 3'h3,
      RB_INVALID       = 3'h4,
      RB_DIE_TEMP      = 3'h5,
      RB_EXTERNAL      = 3'h6,
      RB_GROUND        = 3'h7
   } madc_rb_ch_t;

   // one raw sample from the analog converter
   typedef struct packed
   {
      logic                   is_8bit;
      logic [RESULT_BITS-1:0] data;
   } madc_sample_t;

   // result already split into the two readable bytes
   typedef struct packed
   {
      logic [7:0] upper;
      logic [7:0] lower;
   } madc_result_t;

   typedef enum logic [1:0]
   {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT = 2'b01
   } madc_seq_state_t;

endpackage

// ### hw/madc_sequencer.sv
`timescale 1ns/100ps
module madc_sequencer
   import madc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    enable,
   input  wire logic                    one_shot,
   input  wire logic                    sweep,
   input  wire madc_pkg::madc_conv_ch_t sel_ch,
   input  wire logic                    restart,
   input  wire logic                    conv_done,
   output logic                         conv_start,
   output madc_pkg::madc_conv_ch_t      conv_channel,
   output logic                         capture,
   output logic [2:0]                   capture_ch
);
   import madc_pkg::*;

   madc_seq_state_t state;
   logic [2:0]      sweep_idx;
   madc_conv_ch_t   sweep_ch;
   logic            pass_done;
   logic            go;

   assign go         = enable && !pass_done && !restart;
   assign capture    = (state == SEQ_WAIT) && conv_done && enable;
   assign capture_ch = conv_channel;
   assign sweep_ch   = madc_conv_ch_t'(sweep_idx);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state        <= SEQ_IDLE;
         conv_start   <= 1'b0;
         conv_channel <= CONV_CURRENT_LIMIT;
      end
      else
      begin
         conv_start <= 1'b0;
         unique case (state)
            SEQ_IDLE:
            begin
               if (go)
               begin
                  conv_start   <= 1'b1;
                  conv_channel <= sweep ? sweep_ch : sel_ch;
                  state        <= SEQ_WAIT;
               end
            end
            SEQ_WAIT:
            begin
               // a disabled converter drops the sample in flight
               if (!enable || conv_done)
               begin
                  state <= SEQ_IDLE;
               end
            end
            default:
            begin
               state <= SEQ_IDLE;
            end
         endcase
      end
   end

   // sweep position and end of a single pass
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sweep_idx <= FIRST_CHANNEL;
         pass_done <= 1'b0;
      end
      else if (restart || !enable)
      begin
         sweep_idx <= FIRST_CHANNEL;
         pass_done <= 1'b0;
      end
      else if (capture)
      begin
         if (sweep)
         begin
            sweep_idx <= (sweep_idx == LAST_CHANNEL) ? FIRST_CHANNEL : sweep_idx + 3'h1;
            if (one_shot && sweep_idx == LAST_CHANNEL)
            begin
               pass_done <= 1'b1;
            end
         end
         else if (one_shot)
         begin
            pass_done <= 1'b1;
         end
      end
   end

   property p_no_start_disabled;
      @(posedge clk) disable iff (rst)
      !enable |=> !conv_start;
   endproperty
   a_no_start_disabled: assert property (p_no_start_disabled)
      else $error("conversion started while disabled");

   property p_single_once;
      @(posedge clk) disable iff (rst)
      capture && one_shot && !sweep && !restart ##1 !restart[*4] |-> !conv_start;
   endproperty
   a_single_once: assert property (p_single_once)
      else $error("single one-pass conversion repeated");

   property p_sweep_wrap;
      @(posedge clk) disable iff (rst)
      capture && sweep && !one_shot && !restart && conv_channel == CONV_GROUND
         ##1 (enable && sweep && !restart)[*2]
      |-> conv_start && conv_channel == CONV_CURRENT_LIMIT;
   endproperty
   a_sweep_wrap: assert property (p_sweep_wrap)
      else $error("continuous sweep did not wrap to channel 0");

   property p_sweep_stop;
      @(posedge clk) disable iff (rst)
      capture && sweep && one_shot && !restart && conv_channel == CONV_GROUND
         ##1 !restart[*3]
      |-> !conv_start;
   endproperty
   a_sweep_stop: assert property (p_sweep_stop)
      else $error("one-pass sweep did not halt after channel 7");

endmodule

// ### tb/madc_control_tb.sv
`timescale 1ns/100ps
module madc_control_tb;
   import madc_pkg::*;
   localparam logic [2:0] REV = 3'h5; // arbitrary value
   logic          clk         = 1'b0;
   logic          rst         = 1'b1;
   logic [7:0]    reg_addr    = 8'h00;
   logic          reg_wr      = 1'b0;
   logic [7:0]    reg_wdata   = 8'h00;
   logic          reg_rd      = 1'b0;
   logic [7:0]    reg_rdata;
   logic          conv_done   = 1'b0;
   madc_sample_t  conv_sample = '0;
   logic          conv_start;
   madc_conv_ch_t conv_channel;
   logic          buffer_bypass;
   logic          input_swap;
   int            fail_count  = 0;
   int            tests_run   = 0;
   int            cycles      = 0;
   logic [7:0]    rv;

   always #2.5 clk = ~clk;

   madc_control #(.SILICON_REVISION(REV)) i_madc_control (
      .clk           (clk),
      .rst           (rst),
      .reg_addr      (reg_addr),
      .reg_wr        (reg_wr),
      .reg_wdata     (reg_wdata),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .conv_done     (conv_done),
      .conv_sample   (conv_sample),
      .conv_start    (conv_start),
      .conv_channel  (conv_channel),
      .buffer_bypass (buffer_bypass),
      .input_swap    (input_swap)
   );

   task automatic report_and_stop;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // sized well above the ~300 cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask

   // waits for a start, checks its channel, then answers with sample s
   task automatic conv(input logic [2:0] ch, input madc_sample_t s);
      int n;
      n = 0;
      while (conv_start !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk8({7'h0, conv_start}, 8'h01);
      chk8({5'h0, conv_channel}, {5'h0, ch});
      @(posedge clk);
      #1;
      conv_done = 1'b1;
      conv_sample = s;
      @(posedge clk);
      #1;
      conv_done = 1'b0;
   endtask

   task automatic no_start(input int n);
      int k;
      k = 0;
      repeat (n)
      begin
         @(posedge clk);
         #1;
         if (conv_start !== 1'b0)
            k++;
      end
      chk8(k[7:0], 8'h00);
   endtask

   task automatic t_reset;
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'h00);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, 8'h00);
      rd(OFF_SETUP, rv);
      chk8(rv, {5'h00, REV});
      rd(OFF_CHANNEL, rv);
      chk8(rv, 8'h00);
      wr(OFF_RESULT_UPPER, 8'hff);
      wr(OFF_RESULT_LOWER, 8'hff);
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'h00);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, 8'h00);
      rd(8'h20, rv);
      chk8(rv, 8'h00);
      $display("done: reset");
   endtask

   task automatic t_setup;
      wr(OFF_SETUP, 8'h1f);
      rd(OFF_SETUP, rv);
      chk8(rv, {5'h03, REV});
      chk8({7'h0, buffer_bypass}, 8'h01);
      chk8({7'h0, input_swap}, 8'h01);
      no_start(20);
      wr(OFF_SETUP, 8'h08);
      rd(OFF_SETUP, rv);
      chk8({6'h0, buffer_bypass, input_swap}, 8'h01);
      wr(OFF_SETUP, 8'h00);
      rd(OFF_SETUP, rv);
      chk8({6'h0, buffer_bypass, input_swap}, 8'h00);
      $display("done: setup");
   endtask

   task automatic t_single;
      madc_sample_t s;
      s = {1'b0, 14'h2a5c};
      wr(OFF_CHANNEL, 8'h1b);
      wr(OFF_SETUP, 8'h80);
      conv(3'h3, {1'b0, 14'h0111});
      conv(3'h3, {1'b0, 14'h0222});
      conv(3'h3, s);
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, s.data[13:6]);
      rd(OFF_CHANNEL, rv);
      chk8(rv, 8'h9b);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, {2'b00, s.data[5:0]});
      rd(OFF_CHANNEL, rv);
      chk8(rv, 8'h1b);
      wr(OFF_SETUP, 8'h00);
      $display("done: single continuous");
   endtask

   task automatic t_sweep;
      wr(OFF_CHANNEL, 8'h2a);
      wr(OFF_SETUP, 8'ha0);
      for (int k = 0; k < 8; k++)
         conv(k[2:0], {1'b1, 6'h0, 8'ha0 | k[7:0]});
      conv(3'h0, {1'b1, 6'h0, 8'hb0});
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'ha5);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, 8'h00);
      wr(OFF_SETUP, 8'h00);
      $display("done: sweep continuous");
   endtask

   task automatic t_oneshot;
      wr(OFF_CHANNEL, 8'h36);
      wr(OFF_SETUP, 8'hc0);
      conv(3'h6, {1'b0, 14'h3fff});
      no_start(40);
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'hff);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, 8'h3f);
      wr(OFF_SETUP, 8'h00);
      wr(OFF_SETUP, 8'he0);
      for (int k = 0; k < 8; k++)
         conv(k[2:0], {1'b1, 6'h0, 8'h50 + k[7:0]});
      no_start(40);
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'h56);
      wr(OFF_SETUP, 8'h00);
      $display("done: one pass");
   endtask

   // the late done must not be stored once enable drops
   task automatic t_disable;
      wr(OFF_CHANNEL, 8'h1b);
      wr(OFF_SETUP, 8'h80);
      conv(3'h3, {1'b0, 14'h0fc0});
      wr(OFF_SETUP, 8'h00);
      // done lands while the sequencer still waits but enable is already low
      conv_done = 1'b1;
      conv_sample = {1'b0, 14'h1555};
      @(posedge clk);
      #1;
      conv_done = 1'b0;
      no_start(30);
      rd(OFF_RESULT_UPPER, rv);
      chk8(rv, 8'h3f);
      rd(OFF_RESULT_LOWER, rv);
      chk8(rv, 8'h00);
      $display("done: disable");
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_setup();
      t_single();
      t_sweep();
      t_oneshot();
      t_disable();
      report_and_stop();
   end
endmodule
